// ---- src/tsmc_regs.vh ----
// Notes on behaviour
// RULE1: answer bus address 100 plus 1110
// RULE2: halt bit 6 low: convert continuously
// RULE3: halt bit high: abort conversion, standby
// RULE4: standby: one conversion per one-shot command
// RULE5: host avoids one-shot during auto conversion
// RULE6: host writes spare bits 5:0 as zero
// RULE7: bit 7 masks alert; config resets zero
// RULE8: alert when reading leaves threshold window
`ifndef TSMC_REGS_VH
`define TSMC_REGS_VH

// bus address, fixed upper and selectable lower part
`define TSMC_ADDR_FIXED    3'h4
`define TSMC_ADDR_SELECT   4'hE

// command codes
`define TSMC_CMD_RD_LOCAL  8'h00
`define TSMC_CMD_RD_REMOTE 8'h01
`define TSMC_CMD_RD_CFG    8'h03
`define TSMC_CMD_RD_HIGH   8'h05
`define TSMC_CMD_RD_LOW    8'h06
`define TSMC_CMD_WR_CFG    8'h09
`define TSMC_CMD_WR_HIGH   8'h0B
`define TSMC_CMD_WR_LOW    8'h0C
`define TSMC_CMD_ONE_SHOT  8'h0F

// sensor_mode_config layout
`define TSMC_CFG_MASK_BIT  7
`define TSMC_CFG_HALT_BIT  6
`define TSMC_CFG_KEEP      8'hC0
`define TSMC_CFG_RESET     8'h00

// threshold reset values
`define TSMC_HIGH_RESET    8'h7F
`define TSMC_LOW_RESET     8'h00

// conversion timing
`define TSMC_CLK_MHZ       10
`define TSMC_CONV_TIME_US  1000
`define TSMC_CONV_CYCLES   (`TSMC_CONV_TIME_US * `TSMC_CLK_MHZ)

`endif

// ---- src/tsmc_sensor.v ----
`timescale 1ns/100ps
`default_nettype none
`include "tsmc_regs.vh"

module tsmc_sensor #(
	parameter CONV_CYCLES = `TSMC_CONV_CYCLES
) (
	// clock and reset
	input  wire       core_clk,
	input  wire       srst,
	// bus pins
	input  wire       smb_clk,
	input  wire       smb_dat_in,
	output reg        smb_dat_out,
	output reg        smb_dat_oe,
	// alert pin, open drain
	output reg        alert_n_out,
	output reg        alert_n_oe,
	// converter front end
	input  wire [7:0] local_temp_in,
	input  wire [7:0] remote_temp_in,
	output reg        conv_active
);

	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_RX   = 3'h1;
	localparam [2:0] S_ACK  = 3'h2;
	localparam [2:0] S_TX   = 3'h3;
	localparam [2:0] S_MACK = 3'h4;

	localparam [1:0] PH_ADDR = 2'h0;
	localparam [1:0] PH_CMD  = 2'h1;
	localparam [1:0] PH_DATA = 2'h2;

	reg  [1:0]  scl_sync;
	reg  [1:0]  sda_sync;
	reg         scl_q;
	reg         sda_q;
	reg  [2:0]  st;
	reg  [1:0]  ph;
	reg  [3:0]  bitcnt;
	reg  [7:0]  shreg;
	reg         rw;
	reg  [7:0]  ptr;
	reg  [7:0]  sensor_mode_config;
	reg  [7:0]  thr_high;
	reg  [7:0]  thr_low;
	reg  [7:0]  local_temp;
	reg  [7:0]  remote_temp;
	reg         oneshot_req;
	reg  [31:0] conv_cnt;
	reg         halt_q;

	wire scl_s    = scl_sync[1];
	wire sda_s    = sda_sync[1];
	wire start    = scl_s & scl_q & sda_q & ~sda_s;
	wire stop     = scl_s & scl_q & ~sda_q & sda_s;
	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire halt     = sensor_mode_config[`TSMC_CFG_HALT_BIT];
	wire mask     = sensor_mode_config[`TSMC_CFG_MASK_BIT];
	wire conv_done = conv_active & (conv_cnt == CONV_CYCLES - 1);

	// read data for a command code
	function [7:0] read_mux;
		input [7:0] cmd;
		begin
			case (cmd)
				`TSMC_CMD_RD_LOCAL:  read_mux = local_temp;
				`TSMC_CMD_RD_REMOTE: read_mux = remote_temp;
				`TSMC_CMD_RD_CFG:    read_mux = sensor_mode_config;
				`TSMC_CMD_RD_HIGH:   read_mux = thr_high;
				`TSMC_CMD_RD_LOW:    read_mux = thr_low;
				default:             read_mux = 8'h00;
			endcase
		end
	endfunction

	wire [7:0] rd_byte = read_mux(ptr);

	// reading outside the threshold window
	function beyond;
		input [7:0] t;
		begin
			beyond = (t > thr_high) | (t < thr_low);
		end
	endfunction

	// pin synchronisers
	always @(posedge core_clk) begin
		if (srst) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], smb_clk};
			sda_sync <= {sda_sync[0], smb_dat_in};
			scl_q    <= scl_s;
			sda_q    <= sda_s;
		end
	end

	// bus target
	always @(posedge core_clk) begin
		if (srst) begin
			st                 <= S_IDLE;
			ph                 <= PH_ADDR;
			bitcnt             <= 4'h0;
			shreg              <= 8'h00;
			rw                 <= 1'b0;
			ptr                <= 8'h00;
			sensor_mode_config <= `TSMC_CFG_RESET; // RULE7
			thr_high           <= `TSMC_HIGH_RESET;
			thr_low            <= `TSMC_LOW_RESET;
			oneshot_req        <= 1'b0;
			smb_dat_out        <= 1'b0;
			smb_dat_oe         <= 1'b0;
		end else begin
			oneshot_req <= 1'b0;
			if (stop) begin
				st         <= S_IDLE;
				smb_dat_oe <= 1'b0;
			end else if (start) begin
				st         <= S_RX;
				ph         <= PH_ADDR;
				bitcnt     <= 4'h0;
				smb_dat_oe <= 1'b0;
			end else begin
				case (st)
					S_RX: begin
						if (scl_rise) begin
							shreg  <= {shreg[6:0], sda_s};
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && bitcnt == 4'h8) begin
							bitcnt <= 4'h0;
							case (ph)
								PH_ADDR: begin
									if (shreg[7:1] == {`TSMC_ADDR_FIXED,
										`TSMC_ADDR_SELECT}) begin // RULE1
										rw         <= shreg[0];
										smb_dat_oe <= 1'b1;
										st         <= S_ACK;
									end else begin
										st <= S_IDLE;
									end
								end
								PH_CMD: begin
									ptr         <= shreg;
									oneshot_req <= (shreg == `TSMC_CMD_ONE_SHOT);
									smb_dat_oe  <= 1'b1;
									st          <= S_ACK;
								end
								default: begin
									case (ptr)
										`TSMC_CMD_WR_CFG:
											sensor_mode_config <=
												shreg & `TSMC_CFG_KEEP;
										`TSMC_CMD_WR_HIGH: thr_high <= shreg;
										`TSMC_CMD_WR_LOW:  thr_low  <= shreg;
										default: ;
									endcase
									smb_dat_oe <= 1'b1;
									st         <= S_ACK;
								end
							endcase
						end
					end
					S_ACK: begin
						if (scl_fall) begin
							if (rw) begin
								shreg      <= rd_byte;
								smb_dat_oe <= ~rd_byte[7];
								bitcnt     <= 4'h1;
								st         <= S_TX;
							end else begin
								smb_dat_oe <= 1'b0;
								ph         <= (ph == PH_ADDR) ? PH_CMD : PH_DATA;
								st         <= S_RX;
							end
						end
					end
					S_TX: begin
						if (scl_fall) begin
							if (bitcnt == 4'h8) begin
								smb_dat_oe <= 1'b0;
								st         <= S_MACK;
							end else begin
								shreg      <= {shreg[6:0], 1'b0};
								smb_dat_oe <= ~shreg[6];
								bitcnt     <= bitcnt + 4'h1;
							end
						end
					end
					S_MACK: begin
						if (scl_rise)
							st <= sda_s ? S_IDLE : S_ACK;
					end
					default: begin
						smb_dat_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// conversion engine
	always @(posedge core_clk) begin
		if (srst) begin
			conv_active <= 1'b0;
			conv_cnt    <= 32'h0000_0000;
			halt_q      <= 1'b0;
			local_temp  <= 8'h00;
			remote_temp <= 8'h00;
		end else begin
			halt_q <= halt;
			// completion wins over a same-edge abort
			if (conv_done) begin
				conv_active <= 1'b0;
				local_temp  <= local_temp_in;
				remote_temp <= remote_temp_in;
			end else if (conv_active) begin
				// abort only on the halt write, not on a one-shot run
				if (halt && !halt_q) begin
					conv_active <= 1'b0; // RULE3
					conv_cnt    <= 32'h0000_0000;
				end else begin
					conv_cnt <= conv_cnt + 32'h0000_0001;
				end
			end else if (!halt) begin
				conv_active <= 1'b1; // RULE2
				conv_cnt    <= 32'h0000_0000;
			end else if (oneshot_req) begin
				conv_active <= 1'b1; // RULE4
				conv_cnt    <= 32'h0000_0000;
			end
		end
	end

	// alert pin drive
	always @(posedge core_clk) begin
		if (srst) begin
			alert_n_out <= 1'b0;
			alert_n_oe  <= 1'b0;
		end else begin
			alert_n_out <= 1'b0;
			alert_n_oe  <= ~mask & // RULE7
				(beyond(local_temp) | beyond(remote_temp)); // RULE8
		end
	end

endmodule // tsmc_sensor
`default_nettype wire

// ---- tb/tsmc_sensor_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module tsmc_sensor_asserts #(
	parameter CONV_CYCLES = 20
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// watched pins
	input wire logic smb_clk,
	input wire logic smb_dat_out,
	input wire logic smb_dat_oe,
	input wire logic alert_n_out,
	input wire logic alert_n_oe,
	input wire logic conv_active
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic [15:0] run_len;
	always_ff @(posedge core_clk)
		run_len <= (srst || !conv_active) ? 16'h0000 : run_len + 16'h0001;
	a_ack_clk_low: assert property ($rose(smb_dat_oe) |-> !smb_clk)
		else $error("data pulled while bus clock high");
	a_rel_clk_low: assert property ($fell(smb_dat_oe) |-> !smb_clk)
		else $error("data released while bus clock high");
	a_conv_len: assert property (run_len <= CONV_CYCLES)
		else $error("conversion longer than its count");
	sequence s_auto_start;
		!conv_active ##[1:2] conv_active;
	endsequence
	a_reset_auto: assert property ($fell(srst) |-> s_auto_start)
		else $error("no auto conversion after reset");
	a_open_drain: assert property (!smb_dat_out && !alert_n_out)
		else $error("open drain pin driven high");
	a_alert_cause: assert property ($changed(alert_n_oe) |->
		$past(smb_dat_oe) || !$past(conv_active) || !$past(conv_active, 2))
		else $error("alert moved without a cause");
endmodule // tsmc_sensor_asserts
bind tsmc_sensor tsmc_sensor_asserts #(.CONV_CYCLES(CONV_CYCLES)) chk_u (
	.core_clk(core_clk), .srst(srst), .smb_clk(smb_clk),
	.smb_dat_out(smb_dat_out), .smb_dat_oe(smb_dat_oe),
	.alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
	.conv_active(conv_active));
`default_nettype wire

// ---- tb/tsmc_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module tsmc_host (
	// clock and device drive
	input  wire logic core_clk,
	input  wire logic dat_oe,
	// bus pins
	output var  logic scl,
	output wire logic sda
);
	logic pull;
	initial pull = 1'b0;
	initial scl = 1'b1;
	// open drain, pulled up when released
	assign sda = !(pull | dat_oe);
	task automatic hp(input logic c, input logic d);
		repeat (6) @(posedge core_clk);
		scl <= c;
		pull <= !d;
	endtask
	task automatic bit_x(input logic d, output logic s);
		hp(1'b0, !pull);
		hp(1'b0, d);
		hp(1'b1, d);
		s = sda;
	endtask
	task automatic xfer(input logic [7:0] b, output logic [7:0] r,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_x(b[i], r[i]);
		bit_x(1'b1, ack);
		ack = !ack;
	endtask
	task automatic sto();
		hp(1'b0, !pull);
		hp(1'b0, 1'b0);
		hp(1'b1, 1'b0);
		hp(1'b1, 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, c, d, input int n,
		output logic ok);
		logic [7:0] r;
		logic k1, k2, k3;
		hp(1'b1, 1'b0);
		xfer(a, r, k1);
		xfer(c, r, k2);
		k3 = 1'b1;
		if (n > 0)
			xfer(d, r, k3);
		sto();
		ok = k1 & k2 & k3;
	endtask
	task automatic rd(input logic [7:0] c, output logic [7:0] v);
		logic k;
		hp(1'b1, 1'b0);
		xfer(8'h9C, v, k);
		xfer(c, v, k);
		hp(1'b0, !pull);
		hp(1'b0, 1'b1);
		hp(1'b1, 1'b1);
		hp(1'b1, 1'b0);
		xfer(8'h9D, v, k);
		xfer(8'hFF, v, k);
		sto();
	endtask
endmodule // tsmc_host
`default_nettype wire

// ---- tb/thermal_sensor_mode_control_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t value mismatch", $time); end end
module thermal_sensor_mode_control_tb_top;
	logic       core_clk = 1'b0;
	logic       srst = 1'b1;
	logic [7:0] t_loc = 8'h00;
	logic [7:0] t_rem = 8'h10;
	logic       scl, sda, oe, alert, conv, ok;
	logic [7:0] v;
	int         err_count = 0;
	int         check_count = 0;
	always #50 core_clk = ~core_clk;
	tsmc_sensor #(.CONV_CYCLES(20)) dut_u (.core_clk(core_clk),
		.srst(srst), .smb_clk(scl), .smb_dat_in(sda), .smb_dat_out(),
		.smb_dat_oe(oe), .alert_n_out(), .alert_n_oe(alert),
		.local_temp_in(t_loc), .remote_temp_in(t_rem), .conv_active(conv));
	tsmc_host host_u (.core_clk(core_clk), .dat_oe(oe), .scl(scl), .sda(sda));
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_conv(input logic w);
		for (int n = 0; n < 200 && conv !== w; n++)
			@(posedge core_clk);
		if (conv !== w) begin
			err_count++;
			report_and_stop();
		end
	endtask
	task automatic t_reset_addr();
		host_u.rd(8'h03, v);
		`CHK(v, 8'h00)
		`CHK(alert, 1'b0)
		wait_conv(1'b1);
		host_u.wr(8'h9E, 8'h09, 8'h40, 1, ok);
		`CHK(ok, 1'b0)
		host_u.rd(8'h03, v);
		`CHK(v, 8'h00)
	endtask
	task automatic t_halt();
		host_u.wr(8'h9C, 8'h09, 8'h40, 1, ok);
		`CHK(ok, 1'b1)
		`CHK(conv, 1'b0)
		repeat (50) @(posedge core_clk);
		`CHK(conv, 1'b0)
		host_u.rd(8'h03, v);
		`CHK(v, 8'h40)
	endtask
	task automatic t_shot_alert();
		@(posedge core_clk);
		t_loc <= 8'h90;
		host_u.wr(8'h9C, 8'h0F, 8'h00, 0, ok);
		`CHK(ok, 1'b1)
		repeat (40) @(posedge core_clk);
		`CHK(alert, 1'b1)
		`CHK(conv, 1'b0)
		host_u.wr(8'h9C, 8'h09, 8'hC0, 1, ok);
		`CHK(alert, 1'b0)
		host_u.wr(8'h9C, 8'h09, 8'h00, 1, ok);
		wait_conv(1'b1);
		`CHK(alert, 1'b1)
	endtask
	task automatic t_regs();
		host_u.wr(8'h9C, 8'h0B, 8'h50, 1, ok);
		`CHK(ok, 1'b1)
		host_u.wr(8'h9C, 8'h0C, 8'h08, 1, ok);
		host_u.rd(8'h05, v);
		`CHK(v, 8'h50)
		host_u.rd(8'h06, v);
		`CHK(v, 8'h08)
		t_loc <= 8'h20;
		t_rem <= 8'h60;
		repeat (50) @(posedge core_clk);
		`CHK(alert, 1'b1)
		host_u.rd(8'h00, v);
		`CHK(v, 8'h20)
		host_u.rd(8'h01, v);
		`CHK(v, 8'h60)
		host_u.rd(8'h07, v);
		`CHK(v, 8'h00)
		t_rem <= 8'h40;
		repeat (50) @(posedge core_clk);
		`CHK(alert, 1'b0)
		t_loc <= 8'h04;
		repeat (50) @(posedge core_clk);
		`CHK(alert, 1'b1)
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		t_reset_addr();
		t_halt();
		t_shot_alert();
		t_regs();
		report_and_stop();
	end
endmodule // thermal_sensor_mode_control_tb_top
`default_nettype wire
